/* verilog/cpl_pkg.sv */
package cpl_pkg;

  localparam int CPL_DW = 32;
  localparam int CPL_OW = 16;
  localparam int CPL_NCNT = 6;
  localparam int CPL_NELEM = 256;
  localparam int CPL_FILE_MIN = 9;
  localparam int CPL_FILE_MAX = 255;

  // Register byte offsets
  localparam logic [7:0] CPL_OFS_CTRL = 8'h00;
  localparam logic [7:0] CPL_OFS_CMD = 8'h04;
  localparam logic [7:0] CPL_OFS_HIGH_CV = 8'h08;
  localparam logic [7:0] CPL_OFS_LOW_CV = 8'h0C;
  localparam logic [7:0] CPL_OFS_HIGH_OUT = 8'h10;
  localparam logic [7:0] CPL_OFS_LOW_OUT = 8'h14;
  localparam logic [7:0] CPL_OFS_ACC_SRC = 8'h18;
  localparam logic [7:0] CPL_OFS_MASK = 8'h1C;
  localparam logic [7:0] CPL_OFS_STATUS = 8'h20;
  localparam logic [7:0] CPL_OFS_ACC = 8'h24;
  localparam logic [7:0] CPL_OFS_OUTPUTS = 8'h28;
  localparam logic [7:0] CPL_OFS_TBL_IDX = 8'h2C;
  localparam logic [7:0] CPL_OFS_TBL_DATA = 8'h30;
  localparam logic [7:0] CPL_OFS_TBL_LEN = 8'h34;

  // Control fields
  localparam int CPL_CTRL_RUN = 0;
  localparam int CPL_CTRL_CAM_EN = 1;
  localparam int CPL_CTRL_SP = 2;
  localparam int CPL_CTRL_CNT_LSB = 4;
  // Command fields
  localparam int CPL_CMD_LOAD = 0;
  localparam int CPL_CMD_ACCRST = 1;
  localparam int CPL_CMD_CNT_LSB = 4;
  // Status fields
  localparam int CPL_ST_ERR = 0;
  localparam int CPL_ST_ELEM_LSB = 8;
  // Table word select: 0 high, 1 low, 2 up pattern, 3 down pattern
  localparam int CPL_TW_LSB = 8;

  localparam logic [CPL_DW-1:0] CPL_RESET_WORD = 32'h0000_0000;
  localparam logic [CPL_DW-1:0] CPL_UNMAPPED_RD = 32'h0000_0000;

  typedef struct packed {
    logic [CPL_DW-1:0] high_compare_value;
    logic [CPL_DW-1:0] low_compare_value;
    logic [CPL_OW-1:0] high_match_output_reg;
    logic [CPL_OW-1:0] low_match_output_reg;
  } cpl_preset_t;

endpackage : cpl_pkg

/* verilog/cpl_counter_preset_load.sv */
`timescale 1ns/1ps
module cpl_counter_preset_load
  import cpl_pkg::*;
#(
  parameter int NELEM = CPL_NELEM,
  parameter int OW    = CPL_OW
)(
  // Clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst,
  // Avalon-MM slave
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  input  wire logic [3:0]        i_avs_byteenable,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Pulse inputs
  input  wire logic              i_pulse,
  input  wire logic              i_dir_up,
  // Outputs
  output logic      [OW-1:0]     o_outputs,
  output logic                   o_match,
  output logic                   o_cnt_err
);

  localparam int EW = $clog2(NELEM);

  // Pin synchronisers
  logic [1:0] pulse_sync_r;
  logic [1:0] dir_sync_r;
  logic       pulse_prev_r;
  logic       step;
  logic       up;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      pulse_sync_r <= 2'h0;
      dir_sync_r   <= 2'h0;
      pulse_prev_r <= 1'b0;
    end
    else
    begin
      pulse_sync_r <= {pulse_sync_r[0], i_pulse};
      dir_sync_r   <= {dir_sync_r[0], i_dir_up};
      pulse_prev_r <= pulse_sync_r[1];
    end
  end

  assign step = pulse_sync_r[1] & ~pulse_prev_r;
  assign up   = dir_sync_r[1];

  // Software registers
  logic [31:0]        ctrl_r;
  logic [31:0]        acc_src_r;
  logic [OW-1:0]      mask_r;
  logic [EW-1:0]      tbl_idx_r;
  logic [1:0]         tbl_word_r;
  logic [EW:0]        tbl_len_r;
  cpl_preset_t        stage_r;
  cpl_preset_t        act_r;
  logic [31:0]        acc_r;
  logic [EW-1:0]      elem_r;
  logic               err_r;
  logic               sp_prev_r;
  logic               acc_wait_r;

  logic [31:0] tbl_hi  [NELEM];
  logic [31:0] tbl_lo  [NELEM];
  logic [OW-1:0] tbl_uo [NELEM];
  logic [OW-1:0] tbl_do [NELEM];

  logic wr;
  logic rd;
  logic [2:0] cmd_cnt;
  logic my_cnt;
  logic do_load;
  logic do_accrst;
  logic sp_rise;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction : be_merge

  function automatic logic valid_elem(input logic [31:0] hi, input logic [31:0] lo);
    return $signed(hi) > $signed(lo);
  endfunction : valid_elem

  // One-cycle waitrequest: accept on second cycle of request
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      acc_wait_r <= 1'b0;
    else
      acc_wait_r <= (i_avs_read | i_avs_write) & ~acc_wait_r;
  end

  assign wr = i_avs_write & acc_wait_r;
  assign rd = i_avs_read & acc_wait_r;
  assign cmd_cnt = i_avs_writedata[CPL_CMD_CNT_LSB +: 3];
  assign my_cnt = (cmd_cnt == ctrl_r[CPL_CTRL_CNT_LSB +: 3]);
  assign do_load = wr && i_avs_address == CPL_OFS_CMD && i_avs_writedata[CPL_CMD_LOAD] && my_cnt;
  assign do_accrst = wr && i_avs_address == CPL_OFS_CMD && i_avs_writedata[CPL_CMD_ACCRST]
                     && my_cnt;
  assign sp_rise = ctrl_r[CPL_CTRL_SP] & ~sp_prev_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_r     <= CPL_RESET_WORD;
      acc_src_r  <= CPL_RESET_WORD;
      mask_r     <= '0;
      tbl_idx_r  <= '0;
      tbl_word_r <= 2'h0;
      tbl_len_r  <= '0;
      stage_r    <= '0;
      sp_prev_r  <= 1'b0;
    end
    else
    begin
      sp_prev_r <= ctrl_r[CPL_CTRL_SP];
      if (wr)
      begin
        case (i_avs_address)
          CPL_OFS_CTRL:
            ctrl_r <= be_merge(ctrl_r, i_avs_writedata, i_avs_byteenable);
          CPL_OFS_HIGH_CV:
            stage_r.high_compare_value <= be_merge(stage_r.high_compare_value,
                                                   i_avs_writedata, i_avs_byteenable);
          CPL_OFS_LOW_CV:
            stage_r.low_compare_value <= be_merge(stage_r.low_compare_value,
                                                  i_avs_writedata, i_avs_byteenable);
          CPL_OFS_HIGH_OUT:
            stage_r.high_match_output_reg <= i_avs_writedata[OW-1:0];
          CPL_OFS_LOW_OUT:
            stage_r.low_match_output_reg <= i_avs_writedata[OW-1:0];
          CPL_OFS_ACC_SRC:
            acc_src_r <= be_merge(acc_src_r, i_avs_writedata, i_avs_byteenable);
          CPL_OFS_MASK:
            mask_r <= i_avs_writedata[OW-1:0];
          CPL_OFS_TBL_IDX:
          begin
            tbl_idx_r  <= i_avs_writedata[EW-1:0];
            tbl_word_r <= i_avs_writedata[CPL_TW_LSB +: 2];
          end
          CPL_OFS_TBL_LEN:
            tbl_len_r <= i_avs_writedata[EW:0];
          default:
            ;
        endcase
      end
    end
  end

  // Cam table storage
  always_ff @(posedge i_sys_clk)
  begin
    if (wr && i_avs_address == CPL_OFS_TBL_DATA)
    begin
      case (tbl_word_r)
        2'h0: tbl_hi[tbl_idx_r] <= i_avs_writedata;
        2'h1: tbl_lo[tbl_idx_r] <= i_avs_writedata;
        2'h2: tbl_uo[tbl_idx_r] <= i_avs_writedata[OW-1:0];
        default: tbl_do[tbl_idx_r] <= i_avs_writedata[OW-1:0];
      endcase
    end
  end

  // Counting and compare
  logic cam_on;
  logic [31:0] acc_nxt;
  logic hit_hi;
  logic hit_lo;
  logic hit;
  logic [EW-1:0] elem_nxt;
  logic [EW-1:0] last_elem;
  logic nxt_ok;
  logic [EW-1:0] elem_skip;
  logic [EW-1:0] elem_ld;
  logic ld_ok;

  assign cam_on = ctrl_r[CPL_CTRL_RUN] & ctrl_r[CPL_CTRL_CAM_EN] & (tbl_len_r != '0);
  assign acc_nxt = up ? acc_r + 32'h1 : acc_r - 32'h1;
  assign hit_hi = step & up & (acc_nxt == act_r.high_compare_value);
  assign hit_lo = step & ~up & (acc_nxt == act_r.low_compare_value);
  assign hit = ctrl_r[CPL_CTRL_RUN] & (hit_hi | hit_lo);
  assign last_elem = EW'(tbl_len_r - 1'b1);
  assign elem_nxt = (elem_r >= last_elem) ? '0 : elem_r + 1'b1;
  assign nxt_ok = valid_elem(tbl_hi[elem_nxt], tbl_lo[elem_nxt]);
  assign elem_skip = (elem_nxt >= last_elem) ? '0 : elem_nxt + 1'b1;
  assign elem_ld = nxt_ok ? elem_nxt : elem_skip;
  assign ld_ok = nxt_ok | valid_elem(tbl_hi[elem_skip], tbl_lo[elem_skip]);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      acc_r <= CPL_RESET_WORD;
    else if (do_accrst)
      acc_r <= acc_src_r;
    else if (ctrl_r[CPL_CTRL_RUN] && step)
      acc_r <= acc_nxt;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      act_r  <= '0;
      elem_r <= '0;
    end
    else if (do_load || sp_rise)
    begin
      act_r  <= stage_r;
      elem_r <= '0;
    end
    else if (cam_on && hit)
    begin
      elem_r <= elem_ld;
      if (ld_ok)
      begin
        act_r.high_compare_value    <= tbl_hi[elem_ld];
        act_r.low_compare_value     <= tbl_lo[elem_ld];
        act_r.high_match_output_reg <= tbl_uo[elem_ld];
        act_r.low_match_output_reg  <= tbl_do[elem_ld];
      end
    end
  end

  // Error flag: set wins over clear by status write
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      err_r <= 1'b0;
    else if (cam_on && hit && !nxt_ok)
      err_r <= 1'b1;
    else if (wr && i_avs_address == CPL_OFS_STATUS && i_avs_writedata[CPL_ST_ERR])
      err_r <= 1'b0;
  end

  // Masked output write
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      o_outputs <= '0;
      o_match   <= 1'b0;
    end
    else
    begin
      o_match <= hit;
      if (hit_hi && ctrl_r[CPL_CTRL_RUN])
        o_outputs <= (o_outputs & ~mask_r) | (act_r.high_match_output_reg & mask_r);
      else if (hit_lo && ctrl_r[CPL_CTRL_RUN])
        o_outputs <= (o_outputs & ~mask_r) | (act_r.low_match_output_reg & mask_r);
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_cnt_err <= 1'b0;
    else
      o_cnt_err <= err_r;
  end

  // Read path
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_avs_readdata <= CPL_UNMAPPED_RD;
    else if ((i_avs_read | i_avs_write) && !acc_wait_r)
    begin
      case (i_avs_address)
        CPL_OFS_CTRL:     o_avs_readdata <= ctrl_r;
        CPL_OFS_HIGH_CV:  o_avs_readdata <= act_r.high_compare_value;
        CPL_OFS_LOW_CV:   o_avs_readdata <= act_r.low_compare_value;
        CPL_OFS_HIGH_OUT: o_avs_readdata <= 32'(act_r.high_match_output_reg);
        CPL_OFS_LOW_OUT:  o_avs_readdata <= 32'(act_r.low_match_output_reg);
        CPL_OFS_ACC_SRC:  o_avs_readdata <= acc_src_r;
        CPL_OFS_MASK:     o_avs_readdata <= 32'(mask_r);
        CPL_OFS_STATUS:   o_avs_readdata <= 32'(err_r) | (32'(elem_r) << CPL_ST_ELEM_LSB);
        CPL_OFS_ACC:      o_avs_readdata <= acc_r;
        CPL_OFS_OUTPUTS:  o_avs_readdata <= 32'(o_outputs);
        CPL_OFS_TBL_LEN:  o_avs_readdata <= 32'(tbl_len_r);
        default:          o_avs_readdata <= CPL_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
      o_avs_waitrequest <= 1'b1;
    else
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & ~acc_wait_r);
  end

  // Assertions
  a_accrst_loads: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    do_accrst |=> acc_r == $past(acc_src_r))
    else $error("accumulator reset did not preload source");

  a_load_presets: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    do_load |=> act_r == $past(stage_r))
    else $error("load did not transfer staged presets");

  a_mask_keeps: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    1'b1 |=> ((o_outputs ^ $past(o_outputs)) & ~$past(mask_r)) == '0)
    else $error("unmasked output changed");

  a_up_pattern: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (hit_hi && ctrl_r[CPL_CTRL_RUN])
      |=> (o_outputs & $past(mask_r)) == ($past(act_r.high_match_output_reg) & $past(mask_r)))
    else $error("up match pattern not applied");

  a_down_pattern: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (hit_lo && ctrl_r[CPL_CTRL_RUN])
      |=> (o_outputs & $past(mask_r)) == ($past(act_r.low_match_output_reg) & $past(mask_r)))
    else $error("down match pattern not applied");

  a_elem_wrap: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cam_on && hit && !do_load && !sp_rise && elem_r >= last_elem && nxt_ok) |=> elem_r == '0)
    else $error("element index did not wrap");

  a_elem_adv: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cam_on && hit && !do_load && !sp_rise && nxt_ok) |=> elem_r == $past(elem_nxt))
    else $error("element index did not advance");

  a_err_sticky: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (cam_on && hit && !nxt_ok) |=> err_r ##1 o_cnt_err)
    else $error("invalid element not flagged");

  a_sp_edge: assert property (@(posedge i_sys_clk) disable iff (i_rst)
    (sp_rise && !do_load) |=> act_r == $past(stage_r))
    else $error("parameter bit edge did not transfer");

endmodule : cpl_counter_preset_load

/* test/cpl_pulse_src.sv */
`timescale 1ns/1ps
// Pulse source on the counter's pulse and direction pins
module cpl_pulse_src (
  // Clock
  input  wire logic i_sys_clk,
  // Pins
  output logic      o_pulse,
  output logic      o_dir_up
);
  initial
  begin
    o_pulse  = 1'b0;
    o_dir_up = 1'b1;
  end
  // Direction settles first; each pulse phase lasts half cycles
  task automatic burst(input int n, input logic up, input int half);
    int i;
    o_dir_up <= up;
    repeat (half) @(posedge i_sys_clk);
    for (i = 0; i < n; i++)
    begin
      o_pulse <= 1'b1;
      repeat (half) @(posedge i_sys_clk);
      o_pulse <= 1'b0;
      repeat (half) @(posedge i_sys_clk);
    end
  endtask : burst
endmodule : cpl_pulse_src

/* test/counter_preset_load_and_cam_table_test.sv */
`timescale 1ns/1ps
module counter_preset_load_and_cam_table_test;
  import cpl_pkg::*;
  logic        i_sys_clk;
  logic        i_rst;
  logic [7:0]  av_addr;
  logic        av_rd;
  logic        av_wr;
  logic [31:0] av_wdata;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic        pulse;
  logic        dir_up;
  logic [15:0] outs;
  logic        match;
  logic        cnt_err;
  logic [31:0] rd;
  int          err_total;
  int          tests_run;
  int          n_match;

  cpl_counter_preset_load uut (
    .i_sys_clk         (i_sys_clk),
    .i_rst             (i_rst),
    .i_avs_address     (av_addr),
    .i_avs_read        (av_rd),
    .i_avs_write       (av_wr),
    .i_avs_writedata   (av_wdata),
    .i_avs_byteenable  (4'hF),
    .o_avs_readdata    (av_rdata),
    .o_avs_waitrequest (av_wait),
    .i_pulse           (pulse),
    .i_dir_up          (dir_up),
    .o_outputs         (outs),
    .o_match           (match),
    .o_cnt_err         (cnt_err)
  );

  cpl_pulse_src src (
    .i_sys_clk (i_sys_clk),
    .o_pulse   (pulse),
    .o_dir_up  (dir_up)
  );

  initial
  begin
    i_sys_clk = 1'b0;
    forever #4 i_sys_clk = ~i_sys_clk;
  end

  always @(posedge i_sys_clk)
    if (match === 1'b1)
      n_match <= n_match + 1;

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask : chk

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge i_sys_clk);
    av_addr  <= a;
    av_wdata <= d;
    av_wr    <= wr;
    av_rd    <= ~wr;
    for (k = 0; k < 50; k++)
    begin
      @(posedge i_sys_clk);
      if (av_wait === 1'b0)
        break;
    end
    if (k == 50)
    begin
      err_total++;
      tally_and_finish();
    end
    else
    begin
      rd = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rdc

  task automatic tbl(input logic [7:0] e, input logic [1:0] w, input logic [31:0] d);
    wr(CPL_OFS_TBL_IDX, {22'h0, w, e});
    wr(CPL_OFS_TBL_DATA, d);
  endtask : tbl

  // Pulses plus sync and update latency
  task automatic pulses(input int n, input logic up, input int half);
    @(posedge i_sys_clk);
    src.burst(n, up, half);
    repeat (4) @(posedge i_sys_clk);
  endtask : pulses

  initial
  begin
    i_rst     = 1'b1;
    av_addr   = 8'h00;
    av_rd     = 1'b0;
    av_wr     = 1'b0;
    av_wdata  = 32'h0000_0000;
    err_total = 0;
    tests_run = 0;
    n_match   = 0;
    repeat (12) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    rdc("outputs", CPL_OFS_OUTPUTS, 32'h0000_0000);
    rdc("status", CPL_OFS_STATUS, 32'h0000_0000);
    rdc("unmapped", 8'h3C, CPL_UNMAPPED_RD);
    // Counter 2, running, no table
    wr(CPL_OFS_MASK, 32'h0000_0033);
    wr(CPL_OFS_CTRL, 32'h0000_0021);
    wr(CPL_OFS_HIGH_CV, 32'h0000_0003);
    wr(CPL_OFS_LOW_CV, 32'hFFFF_FFFE);
    wr(CPL_OFS_HIGH_OUT, 32'h0000_FFFF);
    wr(CPL_OFS_LOW_OUT, 32'h0000_0000);
    wr(CPL_OFS_CMD, 32'h0000_0021);
    rdc("high active", CPL_OFS_HIGH_CV, 32'h0000_0003);
    wr(CPL_OFS_HIGH_CV, 32'h0000_0007);
    wr(CPL_OFS_CMD, 32'h0000_0031);
    rdc("other counter", CPL_OFS_HIGH_CV, 32'h0000_0003);
    wr(CPL_OFS_HIGH_CV, 32'h0000_0003);
    wr(CPL_OFS_ACC_SRC, 32'h8000_0000);
    wr(CPL_OFS_CMD, 32'h0000_0022);
    rdc("acc min", CPL_OFS_ACC, 32'h8000_0000);
    wr(CPL_OFS_ACC_SRC, 32'h0000_0000);
    wr(CPL_OFS_CMD, 32'h0000_0022);
    rdc("acc zero", CPL_OFS_ACC, 32'h0000_0000);
    pulses(3, 1'b1, 2);
    rdc("up match", CPL_OFS_OUTPUTS, 32'h0000_0033);
    pulses(5, 1'b0, 4);
    rdc("down match", CPL_OFS_OUTPUTS, 32'h0000_0000);
    rdc("acc down", CPL_OFS_ACC, 32'hFFFF_FFFE);
    wr(CPL_OFS_ACC_SRC, 32'h0000_0005);
    wr(CPL_OFS_CMD, 32'h0000_0022);
    pulses(2, 1'b0, 2);
    rdc("high while down", CPL_OFS_OUTPUTS, 32'h0000_0000);
    chk("match count", 32'd2, n_match);
    // Table: element 0 valid, element 1 invalid
    tbl(8'h00, 2'd0, 32'h0000_0004);
    tbl(8'h00, 2'd1, 32'hFFFF_FF9C);
    tbl(8'h00, 2'd2, 32'h0000_0010);
    tbl(8'h00, 2'd3, 32'h0000_0000);
    tbl(8'h01, 2'd0, 32'h0000_0001);
    tbl(8'h01, 2'd1, 32'h0000_0005);
    tbl(8'h01, 2'd2, 32'h0000_0033);
    tbl(8'h01, 2'd3, 32'h0000_0033);
    wr(CPL_OFS_TBL_LEN, 32'h0000_0002);
    wr(CPL_OFS_HIGH_CV, 32'h0000_0002);
    wr(CPL_OFS_LOW_CV, 32'hFFFF_FF9C);
    wr(CPL_OFS_HIGH_OUT, 32'h0000_0001);
    wr(CPL_OFS_CTRL, 32'h0000_0023);
    wr(CPL_OFS_CTRL, 32'h0000_0027);
    rdc("transfer bit", CPL_OFS_HIGH_CV, 32'h0000_0002);
    wr(CPL_OFS_ACC_SRC, 32'h0000_0000);
    wr(CPL_OFS_CMD, 32'h0000_0022);
    pulses(2, 1'b1, 2);
    rdc("cam first", CPL_OFS_OUTPUTS, 32'h0000_0001);
    pulses(2, 1'b1, 2);
    rdc("cam next", CPL_OFS_OUTPUTS, 32'h0000_0010);
    bus(1'b0, CPL_OFS_STATUS, 32'h0000_0000);
    chk("status error", 32'h0000_0001, {31'h0, rd[CPL_ST_ERR]});
    chk("error pin", 32'h0000_0001, {31'h0, cnt_err});
    wr(CPL_OFS_STATUS, 32'h0000_0001);
    bus(1'b0, CPL_OFS_STATUS, 32'h0000_0000);
    chk("error cleared", 32'h0000_0000, {31'h0, rd[CPL_ST_ERR]});
    // Element 1 made valid: walk both elements and wrap to zero
    tbl(8'h01, 2'd0, 32'h0000_0008);
    tbl(8'h01, 2'd2, 32'h0000_0022);
    wr(CPL_OFS_CMD, 32'h0000_0022);
    pulses(8, 1'b1, 2);
    rdc("cam wrap out", CPL_OFS_OUTPUTS, 32'h0000_0022);
    rdc("cam wrap status", CPL_OFS_STATUS, 32'h0000_0000);
    tally_and_finish();
  end
endmodule : counter_preset_load_and_cam_table_test
